/* File: pkg/ufc_pkg.sv */
// Purpose: shared constants and types of the serial channel operation block
// Assumes: registers are one byte wide, addressed by a 16-bit cpu memory address
// Notes: offsets without a fixed home are grouped near the mode register
package ufc_pkg;
  // register offsets
  localparam logic [15:0] ADDR_PORT1_DIR = 16'hff21;
  localparam logic [15:0] ADDR_PORT1_LATCH = 16'hff01;
  localparam logic [15:0] ADDR_ROUTE = 16'hff4f;
  localparam logic [15:0] ADDR_MODE = 16'hff50;
  localparam logic [15:0] ADDR_TX_STATUS = 16'hff52;
  localparam logic [15:0] ADDR_RX_ERR = 16'hff53;
  localparam logic [15:0] ADDR_RX_BUF = 16'hff54;
  localparam logic [15:0] ADDR_TX_BUF = 16'hff55;
  localparam logic [15:0] ADDR_CLK_SEL = 16'hff56;
  localparam logic [15:0] ADDR_DIVIDER = 16'hff57;
  localparam logic [15:0] ADDR_AUX = 16'hff58;
  // reset values
  localparam logic [7:0] RST_PORT1_DIR = 8'hff;
  localparam logic [7:0] RST_PORT1_LATCH = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic [7:0] RST_DIVIDER = 8'hff;
  localparam logic [7:0] RST_AUX = 8'h16;
  // mode register fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CHAR_LEN = 2;
  localparam int MODE_STOP_LEN = 1;
  localparam int MODE_ERR_IRQ = 0;
  // aux control fields
  localparam int AUX_BREAK_FLAG = 7;
  localparam int AUX_BREAK_TRIG = 6;
  localparam int AUX_BREAK_TX_TRIG = 5;
  localparam int AUX_BIT_ORDER = 1;
  localparam int AUX_INVERT = 0;
  // route register fields
  localparam int ROUTE_CAPTURE = 1;
  localparam int ROUTE_EXT_IRQ0 = 0;
  localparam logic [7:0] ROUTE_MASK = 8'h03;
  // pin positions on port 1
  localparam int PIN_TX = 3;
  localparam int PIN_RX = 4;
  // status register fields
  localparam int TXS_BUF_FULL = 1;
  localparam int TXS_SHIFTING = 0;
  localparam int RXE_PARITY = 2;
  localparam int RXE_FRAMING = 1;
  localparam int RXE_OVERRUN = 0;
  // divider floor and widest prescale exponent
  localparam logic [7:0] DIV_MIN = 8'h08;
  localparam logic [3:0] PRESCALE_MAX = 4'ha;

  typedef enum logic [1:0] {
    UFC_PAR_NONE = 2'b00,
    UFC_PAR_ZERO = 2'b01,
    UFC_PAR_ODD = 2'b10,
    UFC_PAR_EVEN = 2'b11
  } ufc_parity_t;
endpackage

/* File: pkg/ufc_frame_if.sv */
// Purpose: frame format and bit timing shared by the transmit and receive engines
// Assumes: driven only by the control module
// Notes: half_tick is the divider output; one bit lasts two of them
`timescale 1ns/1ps
interface ufc_frame_if;
  import ufc_pkg::*;
  logic half_tick;
  logic char8;
  logic two_stop;
  logic lsb_first;
  ufc_parity_t parity;
  modport ctl (output half_tick, output char8, output two_stop, output lsb_first, output parity);
  modport eng (input half_tick, input char8, input two_stop, input lsb_first, input parity);
endinterface

/* File: hdl/ufc_tx_engine.sv */
// Purpose: serialises one character per frame with start, parity and stop bits
// Assumes: clr holds the engine idle; start is taken only while idle
// Notes: line is the uninverted level, high at rest
`timescale 1ns/1ps
module ufc_tx_engine (
  input wire logic clk,
  input wire logic clr,
  ufc_frame_if.eng fr,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic done,
  output logic line
);
  import ufc_pkg::*;
  logic [11:0] sh_q, sh_d;
  logic [3:0] left_q, left_d;
  logic ph_q, ph_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [7:0] ch, rev8;
  logic [6:0] rev7;
  logic par;

  always_comb begin
    rev8 = {<<{data}};
    rev7 = {<<{data[6:0]}};
    ch = fr.lsb_first ? data : rev8;
    if (!fr.char8) begin
      ch = fr.lsb_first ? {1'b0, data[6:0]} : {1'b0, rev7};
    end
    par = ^data[6:0] ^ (fr.char8 & data[7]);
    sh_d = sh_q;
    left_d = left_q;
    ph_d = ph_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (clr) begin
      busy_d = 1'b0;
      sh_d = 12'hfff;
    end else if (!busy_q && start) begin
      // frame laid out lsb-first into the shifter, start bit in bit 0
      sh_d = {12{1'b1}};
      sh_d[0] = 1'b0;
      sh_d[8:1] = ch;
      if (fr.char8) begin
        sh_d[9] = (fr.parity == UFC_PAR_ODD) ? ~par : (fr.parity == UFC_PAR_EVEN) & par;
        if (fr.parity == UFC_PAR_NONE) sh_d[9] = 1'b1;
      end else begin
        sh_d[8] = (fr.parity == UFC_PAR_ODD) ? ~par : (fr.parity == UFC_PAR_EVEN) & par;
        if (fr.parity == UFC_PAR_NONE) sh_d[8] = 1'b1;
      end
      left_d = 4'(8 + 32'(fr.char8) + 32'(fr.parity != UFC_PAR_NONE) + 32'(fr.two_stop));
      ph_d = 1'b0;
      busy_d = 1'b1;
    end else if (busy_q && fr.half_tick) begin
      ph_d = ~ph_q;
      if (ph_q) begin
        sh_d = {1'b1, sh_q[11:1]};
        left_d = left_q - 4'h1;
        if (left_q == 4'h0) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    sh_q <= sh_d;
    left_q <= left_d;
    ph_q <= ph_d;
    busy_q <= busy_d;
    done_q <= done_d;
  end

  assign busy = busy_q;
  assign done = done_q;
  assign line = busy_q ? sh_q[0] : 1'b1;
endmodule

/* File: hdl/ufc_rx_engine.sv */
// Purpose: samples one frame in the first half of each bit and reports character and errors
// Assumes: line is already forced high while the channel is stopped
// Notes: start detection resolves to half a bit, whatever the divider value
`timescale 1ns/1ps
module ufc_rx_engine (
  input wire logic clk,
  input wire logic clr,
  ufc_frame_if.eng fr,
  input wire logic line,
  output logic done,
  output logic [7:0] data,
  output logic par_err,
  output logic frame_err
);
  import ufc_pkg::*;
  logic [9:0] sh_q, sh_d;
  logic [3:0] left_q, left_d;
  logic ph_q, ph_d;
  logic act_q, act_d;
  logic done_q, done_d;
  logic [7:0] data_q, data_d;
  logic pe_q, pe_d;
  logic fe_q, fe_d;
  logic [7:0] ch, rev;
  logic p;

  always_comb begin
    sh_d = sh_q;
    left_d = left_q;
    ph_d = ph_q;
    act_d = act_q;
    done_d = 1'b0;
    data_d = data_q;
    pe_d = pe_q;
    fe_d = fe_q;
    // last bit taken is the stop bit, seen on line; earlier bits sit above the newest in bit 0
    ch = fr.char8 ? sh_q[7:0] : {1'b0, sh_q[6:0]};
    if (fr.parity != UFC_PAR_NONE) ch = fr.char8 ? sh_q[8:1] : {1'b0, sh_q[7:1]};
    // first bit sits highest, so lsb-first needs the reversal
    rev = {<<{ch}};
    if (fr.lsb_first) ch = fr.char8 ? rev : {1'b0, rev[7:1]};
    p = ^sh_q[8:0];
    if (!fr.char8) p = ^sh_q[7:0];
    if (clr) begin
      act_d = 1'b0;
    end else if (fr.half_tick) begin
      if (!act_q) begin
        if (!line) begin
          act_d = 1'b1;
          ph_d = 1'b1;
          left_d = 4'(7 + 32'(fr.char8) + 32'(fr.parity != UFC_PAR_NONE));
          sh_d = 10'h000;
        end
      end else begin
        ph_d = ~ph_q;
        if (!ph_q) begin
          sh_d = {sh_q[8:0], line};
          left_d = left_q - 4'h1;
          if (left_q == 4'h0) begin
            act_d = 1'b0;
            done_d = 1'b1;
            data_d = ch;
            fe_d = ~line;
            pe_d = ((fr.parity == UFC_PAR_EVEN) & p) | ((fr.parity == UFC_PAR_ODD) & ~p);
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    sh_q <= sh_d;
    left_q <= left_d;
    ph_q <= ph_d;
    act_q <= act_d;
    done_q <= done_d;
    data_q <= data_d;
    pe_q <= pe_d;
    fe_q <= fe_d;
  end

  assign done = done_q;
  assign data = data_q;
  assign par_err = pe_q;
  assign frame_err = fe_q;
endmodule

/* File: hdl/ufc_uart_ctrl.sv */
// Purpose: operating control, pin muxing and frame format of the async serial channel
// Assumes: cpu accesses are single-cycle byte reads and writes at 16-bit addresses
// Notes: the stopped state is held by synchronous clears since the block has one clock
// What this block does
// [RULE1] route bit 1 picks capture input: own pin or serial receive line
// [RULE2] route bit 0 picks external interrupt 0 input: own pin or receive line
// [RULE3] route register resets to zero; upper six bits always read zero
// [RULE4] direction bit 0 drives pin as output, 1 makes it input; reset all ones
// [RULE5] software sets transmit pin as output latched high, receive pin as input
// [RULE6] with power, transmit and receive enables clear, channel stops, pins are ports
// [RULE7] mode register resets to 01h with power down to error-interrupt-mode layout
// [RULE8] power bit low freezes baud timing and holds serial circuitry in reset
// [RULE9] power low forces serial output high and receive input high
// [RULE10] power low clears error status, transmit status, break bits, receive buffer
// [RULE11] transmit enable low stops and resets the transmit circuit
// [RULE12] receive enable low stops and resets the receive circuit
// [RULE13] software clears enables before power and sets power before enables
// [RULE14] software sets clock, divider, mode, aux bits before setting power
// [RULE15] writing the transmit buffer while transmitting is enabled starts a frame
// [RULE16] pins carry serial data only when power and matching enable are set
// [RULE17] one byte per frame after start bit, transmit and receive run together
// [RULE18] frame is start, 7 or 8 bits, optional parity, one or two stops
// [RULE19] aux bit 1 selects lsb-first or msb-first character order
// [RULE20] aux bit 0 selects normal or inverted transmit waveform
// [RULE21] invert bit 0 gives normal output, 1 gives inverted output
// [RULE22] bit rate is divider output halved; divider runs from 8 to 255
// [RULE23] idle transmit line rests high unless inversion is selected
`timescale 1ns/1ps
module ufc_uart_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  input wire logic capture_pin_in,
  input wire logic ext_irq0_pin_in,
  output logic timer_capture_input,
  output logic external_interrupt0_input,
  output logic tx_complete,
  output logic rx_complete,
  output logic rx_error
);
  import ufc_pkg::*;

  logic [7:0] port1_direction_q, port1_direction_d;
  logic [7:0] port1_latch_q, port1_latch_d;
  logic [7:0] input_route_select_q, input_route_select_d;
  logic [7:0] serial_mode_control_q, serial_mode_control_d;
  logic [7:0] clock_source_select_q, clock_source_select_d;
  logic [7:0] bit_rate_divider_q, bit_rate_divider_d;
  logic [7:0] serial_aux_control_q, serial_aux_control_d;
  logic [7:0] transmit_buffer_q, transmit_buffer_d;
  logic [7:0] receive_buffer_q, receive_buffer_d;
  logic [2:0] receive_error_status_q, receive_error_status_d;
  logic tx_buf_full_q, tx_buf_full_d;
  logic rx_full_q, rx_full_d;
  logic [7:0] cpu_rdata_q, cpu_rdata_d;
  logic [10:0] pre_cnt_q, pre_cnt_d;
  logic [7:0] div_cnt_q, div_cnt_d;
  logic half_tick_q, half_tick_d;
  logic rx_err_pulse_q, rx_err_pulse_d;

  logic channel_power;
  logic transmit_enable;
  logic receive_enable;
  logic tx_run;
  logic rx_run;
  logic tx_busy;
  logic tx_done;
  logic tx_line;
  logic tx_start;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_par_err;
  logic rx_frame_err;
  logic serial_receive_line;
  logic serial_transmit_level;
  logic wr_txb;

  ufc_frame_if fr ();

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  // terminal count of the prescaler for a select code, clamped to the widest tap
  function automatic logic [10:0] prescale_last(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel;
    prescale_last = 11'((32'd1 << s) - 32'd1);
  endfunction

  assign channel_power = serial_mode_control_q[MODE_POWER];
  assign transmit_enable = serial_mode_control_q[MODE_TXE];
  assign receive_enable = serial_mode_control_q[MODE_RXE];
  // [RULE16] serial roles need power and enable
  assign tx_run = channel_power & transmit_enable;
  assign rx_run = channel_power & receive_enable;
  assign wr_txb = cpu_wr & hit(cpu_addr, ADDR_TX_BUF);

  // register writes and power-down clears
  always_comb begin
    port1_direction_d = port1_direction_q;
    port1_latch_d = port1_latch_q;
    input_route_select_d = input_route_select_q;
    serial_mode_control_d = serial_mode_control_q;
    clock_source_select_d = clock_source_select_q;
    bit_rate_divider_d = bit_rate_divider_q;
    serial_aux_control_d = serial_aux_control_q;
    if (cpu_wr) begin
      if (hit(cpu_addr, ADDR_PORT1_DIR)) begin
        // [RULE4] pin direction per bit
        port1_direction_d = cpu_wdata;
      end else if (hit(cpu_addr, ADDR_PORT1_LATCH)) begin
        port1_latch_d = cpu_wdata;
      end else if (hit(cpu_addr, ADDR_ROUTE)) begin
        // [RULE3] upper bits stay zero
        input_route_select_d = cpu_wdata & ROUTE_MASK;
      end else if (hit(cpu_addr, ADDR_MODE)) begin
        // [RULE7] full mode byte
        serial_mode_control_d = cpu_wdata;
      end else if (hit(cpu_addr, ADDR_CLK_SEL)) begin
        clock_source_select_d = {4'h0, cpu_wdata[3:0]};
      end else if (hit(cpu_addr, ADDR_DIVIDER)) begin
        // [RULE22] values below 8 are prohibited; clamp to the floor
        bit_rate_divider_d = (cpu_wdata < DIV_MIN) ? DIV_MIN : cpu_wdata;
      end else if (hit(cpu_addr, ADDR_AUX)) begin
        // break flag is read-only; triggers are not kept, only the bit 6 trigger acts
        serial_aux_control_d[5:0] = {1'b0, cpu_wdata[4:0]};
        serial_aux_control_d[AUX_BREAK_TRIG] = 1'b0;
        if (cpu_wdata[AUX_BREAK_TRIG] && rx_run) begin
          serial_aux_control_d[AUX_BREAK_FLAG] = 1'b1;
        end
      end
    end
    if (!channel_power) begin
      // [RULE10] break bits cleared while powered down
      serial_aux_control_d[AUX_BREAK_FLAG] = 1'b0;
      serial_aux_control_d[AUX_BREAK_TRIG] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port1_direction_q <= RST_PORT1_DIR;
      port1_latch_q <= RST_PORT1_LATCH;
      input_route_select_q <= RST_ROUTE;
      serial_mode_control_q <= RST_MODE;
      clock_source_select_q <= RST_CLK_SEL;
      bit_rate_divider_q <= RST_DIVIDER;
      serial_aux_control_q <= RST_AUX;
    end else begin
      port1_direction_q <= port1_direction_d;
      port1_latch_q <= port1_latch_d;
      input_route_select_q <= input_route_select_d;
      serial_mode_control_q <= serial_mode_control_d;
      clock_source_select_q <= clock_source_select_d;
      bit_rate_divider_q <= bit_rate_divider_d;
      serial_aux_control_q <= serial_aux_control_d;
    end
  end

  // baud timing: prescaler, then divide by k to make the half-bit tick
  always_comb begin
    pre_cnt_d = pre_cnt_q + 11'h1;
    div_cnt_d = div_cnt_q;
    half_tick_d = 1'b0;
    if (pre_cnt_q >= prescale_last(clock_source_select_q[3:0])) begin
      pre_cnt_d = 11'h000;
      div_cnt_d = div_cnt_q + 8'h01;
      if (div_cnt_q >= bit_rate_divider_q - 8'h01) begin
        div_cnt_d = 8'h00;
        // [RULE22] divider output; engines take two per bit
        half_tick_d = 1'b1;
      end
    end
    if (!channel_power) begin
      // [RULE8] timing frozen while powered down
      pre_cnt_d = 11'h000;
      div_cnt_d = 8'h00;
      half_tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_cnt_q <= 11'h000;
      div_cnt_q <= 8'h00;
      half_tick_q <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_d;
      div_cnt_q <= div_cnt_d;
      half_tick_q <= half_tick_d;
    end
  end

  // [RULE18] frame format from the mode register
  assign fr.half_tick = half_tick_q;
  assign fr.char8 = serial_mode_control_q[MODE_CHAR_LEN];
  assign fr.two_stop = serial_mode_control_q[MODE_STOP_LEN];
  assign fr.parity = ufc_parity_t'(serial_mode_control_q[MODE_PAR_HI:MODE_PAR_LO]);
  // [RULE19] order select
  assign fr.lsb_first = serial_aux_control_q[AUX_BIT_ORDER];

  // transmit buffer: one byte may wait while the shifter runs
  assign tx_start = tx_buf_full_q & ~tx_busy;
  always_comb begin
    transmit_buffer_d = transmit_buffer_q;
    tx_buf_full_d = tx_buf_full_q;
    if (tx_start) begin
      tx_buf_full_d = 1'b0;
    end
    // [RULE15] buffer write starts a frame when enabled
    if (wr_txb && tx_run) begin
      transmit_buffer_d = cpu_wdata;
      tx_buf_full_d = 1'b1;
    end
    if (!tx_run) begin
      // [RULE11] transmit side held in reset
      tx_buf_full_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      transmit_buffer_q <= 8'h00;
      tx_buf_full_q <= 1'b0;
    end else begin
      transmit_buffer_q <= transmit_buffer_d;
      tx_buf_full_q <= tx_buf_full_d;
    end
  end

  // [RULE17] independent engines give full duplex
  ufc_tx_engine u_tx (
    .clk(clk),
    .clr(srst | ~tx_run),
    .fr(fr.eng),
    .start(tx_start),
    .data(transmit_buffer_q),
    .busy(tx_busy),
    .done(tx_done),
    .line(tx_line)
  );

  // [RULE9] receive input fixed high while powered down
  assign serial_receive_line = channel_power ? port1_in[PIN_RX] : 1'b1;

  ufc_rx_engine u_rx (
    .clk(clk),
    .clr(srst | ~rx_run),
    .fr(fr.eng),
    .line(rx_run ? serial_receive_line : 1'b1),
    .done(rx_done),
    .data(rx_data),
    .par_err(rx_par_err),
    .frame_err(rx_frame_err)
  );

  // receive buffer and error status; a new frame wins over a read clear
  always_comb begin
    receive_buffer_d = receive_buffer_q;
    receive_error_status_d = receive_error_status_q;
    rx_full_d = rx_full_q;
    rx_err_pulse_d = 1'b0;
    if (cpu_rd && hit(cpu_addr, ADDR_RX_BUF)) begin
      rx_full_d = 1'b0;
    end
    if (cpu_rd && hit(cpu_addr, ADDR_RX_ERR)) begin
      receive_error_status_d = 3'b000;
    end
    if (rx_done) begin
      receive_buffer_d = rx_data;
      rx_full_d = 1'b1;
      receive_error_status_d[RXE_PARITY] = receive_error_status_d[RXE_PARITY] | rx_par_err;
      receive_error_status_d[RXE_FRAMING] = receive_error_status_d[RXE_FRAMING] | rx_frame_err;
      receive_error_status_d[RXE_OVERRUN] = receive_error_status_d[RXE_OVERRUN] | rx_full_q;
      rx_err_pulse_d = rx_par_err | rx_frame_err | rx_full_q;
    end
    if (!channel_power) begin
      // [RULE10] receive status and buffer cleared
      receive_buffer_d = 8'h00;
      receive_error_status_d = 3'b000;
      rx_full_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      receive_buffer_q <= 8'h00;
      receive_error_status_q <= 3'b000;
      rx_full_q <= 1'b0;
      rx_err_pulse_q <= 1'b0;
    end else begin
      receive_buffer_q <= receive_buffer_d;
      receive_error_status_q <= receive_error_status_d;
      rx_full_q <= rx_full_d;
      rx_err_pulse_q <= rx_err_pulse_d;
    end
  end

  // read data is registered, unmapped reads return zero
  always_comb begin
    cpu_rdata_d = 8'h00;
    if (cpu_rd) begin
      if (hit(cpu_addr, ADDR_PORT1_DIR)) begin
        cpu_rdata_d = port1_direction_q;
      end else if (hit(cpu_addr, ADDR_PORT1_LATCH)) begin
        cpu_rdata_d = port1_latch_q;
      end else if (hit(cpu_addr, ADDR_ROUTE)) begin
        cpu_rdata_d = input_route_select_q;
      end else if (hit(cpu_addr, ADDR_MODE)) begin
        cpu_rdata_d = serial_mode_control_q;
      end else if (hit(cpu_addr, ADDR_TX_STATUS)) begin
        // [RULE10] status reads zero once powered down
        cpu_rdata_d[TXS_BUF_FULL] = tx_buf_full_q;
        cpu_rdata_d[TXS_SHIFTING] = tx_busy;
      end else if (hit(cpu_addr, ADDR_RX_ERR)) begin
        cpu_rdata_d = {5'h00, receive_error_status_q};
      end else if (hit(cpu_addr, ADDR_RX_BUF)) begin
        cpu_rdata_d = receive_buffer_q;
      end else if (hit(cpu_addr, ADDR_CLK_SEL)) begin
        cpu_rdata_d = clock_source_select_q;
      end else if (hit(cpu_addr, ADDR_DIVIDER)) begin
        cpu_rdata_d = bit_rate_divider_q;
      end else if (hit(cpu_addr, ADDR_AUX)) begin
        cpu_rdata_d = serial_aux_control_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_rdata_q <= 8'h00;
    end else begin
      cpu_rdata_q <= cpu_rdata_d;
    end
  end

  assign cpu_rdata = cpu_rdata_q;

  // [RULE9] serial level is high when powered down
  // [RULE20] inversion applied to the whole waveform
  // [RULE21] invert bit 1 means inverted
  // [RULE23] idle engine line is high, so rest level follows inversion
  assign serial_transmit_level = channel_power ?
    (tx_line ^ serial_aux_control_q[AUX_INVERT]) : 1'b1;

  // [RULE6] stopped channel leaves both pins as plain ports
  // [RULE16] transmit pin takes serial data only while running
  always_comb begin
    port1_out = port1_latch_q;
    if (tx_run) begin
      port1_out[PIN_TX] = serial_transmit_level;
    end
    // [RULE4] direction 0 turns the output buffer on
    port1_oe = ~port1_direction_q;
  end

  // [RULE1] capture input source
  assign timer_capture_input = input_route_select_q[ROUTE_CAPTURE] ?
    serial_receive_line : capture_pin_in;
  // [RULE2] external interrupt 0 source
  assign external_interrupt0_input = input_route_select_q[ROUTE_EXT_IRQ0] ?
    serial_receive_line : ext_irq0_pin_in;

  assign tx_complete = tx_done;
  assign rx_complete = rx_done;
  assign rx_error = rx_err_pulse_q;
endmodule

/* File: testbench/ufc_chk.sv */
// Purpose: port checks of the serial control block
// Assumes: shadows follow cpu writes at the taking edge
// Notes: only the registers the checks need are shadowed
`timescale 1ns/1ps
module ufc_chk
  import ufc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic capture_pin_in,
  input wire logic ext_irq0_pin_in,
  input wire logic timer_capture_input,
  input wire logic external_interrupt0_input,
  input wire logic tx_complete,
  input wire logic rx_complete
);
  logic [7:0] dir_q, lat_q, rt_q, md_q;
  logic txon, rxon;
  assign txon = md_q[MODE_POWER] & md_q[MODE_TXE];
  assign rxon = md_q[MODE_POWER] & md_q[MODE_RXE];
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_q <= 8'hff;
      lat_q <= 8'h00;
      rt_q <= 8'h00;
      md_q <= 8'h01;
    end else if (cpu_wr) begin
      if (cpu_addr == ADDR_PORT1_DIR) dir_q <= cpu_wdata;
      if (cpu_addr == ADDR_PORT1_LATCH) lat_q <= cpu_wdata;
      if (cpu_addr == ADDR_ROUTE) rt_q <= cpu_wdata & 8'h03;
      if (cpu_addr == ADDR_MODE) md_q <= cpu_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_dir_oe: assert property (port1_oe == ~dir_q)
    else $error("oe differs from direction");
  a_cap_route: assert property (!rt_q[1] |-> timer_capture_input == capture_pin_in)
    else $error("capture route wrong");
  a_irq_route: assert property (!rt_q[0] |-> external_interrupt0_input == ext_irq0_pin_in)
    else $error("irq route wrong");
  a_mode_read: assert property (cpu_rd && cpu_addr == ADDR_MODE |=> cpu_rdata == md_q)
    else $error("mode readback wrong");
  a_route_read: assert property (cpu_rd && cpu_addr == ADDR_ROUTE |=> cpu_rdata == rt_q)
    else $error("route readback wrong");
  a_tx_port: assert property (!txon |-> port1_out[PIN_TX] == lat_q[PIN_TX])
    else $error("tx pin not a port");
  a_tx_quiet: assert property (!txon && !$past(txon) |-> !tx_complete)
    else $error("tx done while off");
  a_rx_quiet: assert property (!rxon && !$past(rxon) |-> !rx_complete)
    else $error("rx done while off");
  c_tx: cover property (tx_complete);
  c_rx: cover property (rx_complete);
  c_route: cover property (cpu_rd && cpu_addr == ADDR_ROUTE);
endmodule

/* File: testbench/ufc_peer.sv */
// Purpose: remote serial node, eight bits lsb first, one stop
// Assumes: one bit lasts BITC clocks
// Notes: line rests high, as a pulled-up idle line would
`timescale 1ns/1ps
module ufc_peer #(parameter int BITC = 16) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic [7:0] got
);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    for (int i = -1; i < 9; i++) begin
      rxd = (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
      repeat (BITC) @(posedge clk);
      #1;
    end
  endtask
  always begin
    // skip the unknown-to-low step at reset and any low port level
    wait (txd === 1'b1);
    @(negedge txd);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clk);
      got[i] = txd;
    end
  end
endmodule

/* File: testbench/uart_operation_and_frame_control_tb.sv */
// Purpose: self-checking bench of the serial control block
// Assumes: divider 8, so a bit is 16 clocks
// Notes: peer decodes lsb first, so msb-first shows reversed
`timescale 1ns/1ps
module uart_operation_and_frame_control_tb;
  import ufc_pkg::*;
  logic clk = 0, srst = 1, cpu_wr = 0, cpu_rd = 0, rxd;
  logic capture_pin_in = 0, ext_irq0_pin_in = 0, tx_complete, rx_complete, rx_error;
  logic timer_capture_input, external_interrupt0_input;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00, cpu_rdata, port1_in, port1_out, port1_oe, got;
  int n_mismatch = 0, n_checks = 0, n_tx = 0, n_rx = 0, n_err = 0;
  assign port1_in = {3'h0, rxd, 4'h0};
  ufc_uart_ctrl dut_u (.*);
  ufc_peer peer_u (.clk(clk), .txd(port1_out[PIN_TX]), .rxd(rxd), .got(got));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_tx += tx_complete;
    n_rx += rx_complete;
    n_err += rx_error;
  end
  task automatic stp;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1;
    stp;
    cpu_wr = 0;
    stp;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk(input string n, input logic [15:0] a, input logic [7:0] e);
    cpu_addr = a;
    cpu_rd = 1;
    stp;
    cmp(n, e, cpu_rdata);
    cpu_rd = 0;
    stp;
  endtask
  task automatic t_regs;
    chk("dir", ADDR_PORT1_DIR, 8'hff);
    chk("route", ADDR_ROUTE, 8'h00);
    chk("mode", ADDR_MODE, 8'h01);
    wr(ADDR_PORT1_DIR, 8'hf7);
    cmp("oe", 8'h08, port1_oe);
  endtask
  task automatic t_route;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_ROUTE, 8'hfc | r[7:0]);
      chk("route", ADDR_ROUTE, r[7:0]);
      cmp("routed", r[7:0], {6'h0, timer_capture_input, external_interrupt0_input});
    end
  endtask
  task automatic t_duplex;
    wr(ADDR_CLK_SEL, 8'h00);
    wr(ADDR_DIVIDER, 8'h08);
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_MODE, 8'h84);
    cmp("txport", 8'h00, {7'h0, port1_out[PIN_TX]});
    wr(ADDR_PORT1_LATCH, 8'h08);
    wr(ADDR_MODE, 8'he4);
    fork
      peer_u.send(8'h3c);
      wr(ADDR_TX_BUF, 8'ha5);
    join
    for (int i = 0; i < 300 && n_tx < 1; i++) stp;
    cmp("txbyte", 8'ha5, got);
    chk("rxbyte", ADDR_RX_BUF, 8'h3c);
    cmp("frames", 8'h02, 8'(n_tx + n_rx));
    cmp("rxerr", 8'h00, 8'(n_err));
  endtask
  task automatic t_order;
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_AUX, 8'h14);
    wr(ADDR_MODE, 8'hc4);
    wr(ADDR_TX_BUF, 8'h1e);
    for (int i = 0; i < 300 && n_tx < 2; i++) stp;
    cmp("msbfirst", 8'h78, got);
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_AUX, 8'h15);
    wr(ADDR_MODE, 8'hc4);
    cmp("invidle", 8'h00, {7'h0, port1_out[PIN_TX]});
  endtask
  task automatic t_stop;
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_AUX, 8'h16);
    wr(ADDR_MODE, 8'hd8);
    wr(ADDR_TX_BUF, 8'h57);
    for (int i = 0; i < 300 && n_tx < 3; i++) stp;
    cmp("parity7", 8'hd7, got);
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_TX_BUF, 8'h55);
    repeat (200) stp;
    cmp("nostart", 8'h03, 8'(n_tx));
    chk("rxclear", ADDR_RX_BUF, 8'h00);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 srst = 0;
    t_regs;
    t_route;
    t_duplex;
    t_order;
    t_stop;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule
bind ufc_uart_ctrl ufc_chk chk_u (.*);
